// ### src/cams_regs.svh
`ifndef CAMS_REGS_SVH
`define CAMS_REGS_SVH

// ----------------------------------------------------------------
// Map geometry
// ----------------------------------------------------------------
`define CAMS_NUM_CH 22
`define CAMS_CH_STRIDE 11'h040
`define CAMS_CH0_BLOCK 5'h1f
`define CAMS_LAST_BLOCK 5'h14

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define CAMS_IDX_MASK_A 6'h1c
`define CAMS_IDX_MASK_B 6'h1d
`define CAMS_IDX_LIVE_A 6'h1e
`define CAMS_IDX_LIVE_B 6'h1f
`define CAMS_IDX_LATCH_B 6'h21
`define CAMS_IDX_LATCH_EV 6'h22
`define CAMS_IDX_EDGE_SEL 6'h23

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CAMS_RST_MASK_A 8'hef
`define CAMS_RST_MASK_B 8'h3f
`define CAMS_RST_STATUS 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CAMS_B_SYS_AIS 7
`define CAMS_B_LINE_AIS 6
`define CAMS_B_PRBS_SYNC 5
`define CAMS_B_LOOPUP 1
`define CAMS_B_LOOPDN 0
`define CAMS_B_AUTO_LB 7
`define CAMS_B_ES_AIS 6
`define CAMS_B_ES_PA 5
`define CAMS_B_ES_LOOP 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CAMS_CLK_KHZ 50000
`define CAMS_T_LOOP_T1_MS 40
`define CAMS_T_LOOPDN_E1_MS 30
`define CAMS_T_LOOP_AUTO_MS 5100

`endif

// ### src/cams_pkg.sv
`default_nettype none

package cams_pkg;

  // Live conditions of the first status register, per channel
  typedef struct packed {
    logic auto_loopback_active;
    logic driver_overload;
    logic tx_clock_absent;
    logic tx_signal_absent;
    logic system_signal_absent;
    logic line_signal_absent;
  } cams_live_a_t;

  // Raw conditions behind the second status register, per channel
  typedef struct packed {
    logic system_side_alarm_indication;
    logic line_side_alarm_indication;
    logic prbs_sync_flag;
    logic loopup_code_present;
    logic loopdown_code_present;
  } cams_live_b_t;

  // One-cycle event pulses, in second-mask bit order 5..0
  typedef struct packed {
    logic system_bipolar_violation;
    logic line_bipolar_violation;
    logic system_excess_zeros;
    logic line_excess_zeros;
    logic prbs_bit_fault;
    logic fault_counter_overflow;
  } cams_event_t;

  typedef enum logic [2:0] {
    CAMS_ST_IDLE = 3'b001,
    CAMS_ST_RDW = 3'b010,
    CAMS_ST_RDD = 3'b100
  } cams_bus_st_t;

endpackage

`default_nettype wire

// ### src/cams_top.sv
// Function
// - Register set repeats per channel every 0x40; channel zero sits at 0x7C0.
// - Mask bit 0 enables its source, 1 suppresses it.
// - First mask register is read/write, resets to 0xEF.
// - First mask bits: system AIS, line AIS, sync, loop-up, loop-down.
// - Second mask resets 0x3F; bits 5..2 mask violations and excess zeros.
// - Second mask bit 1 gates the test sequence bit fault interrupt.
// - Second mask bit 0 gates the fault counter overflow interrupt.
// - Live status registers are read-only, reset 0x00, reserved bits zero.
// - First status bit 7 shows automatic loopback active.
// - First status bits 4..0 show overload, clock, tx, system, line loss.
// - Second status bit 5 shows test sequence in synchronization.
// - Second status bits 7 and 6 show system and line AIS.
// - Loop-up seen after 40 ms, or 5.1 s with auto loopback.
// - Loop-down seen after 40 ms T1/J1, 30 ms E1, or 5.1 s.
// - Edge select 0 latches on rise, 1 latches on either edge.
// - Latched status drives interrupt and clears on read or on writing 1.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "cams_regs.svh"

module cams_top #(
  parameter int unsigned LOOP_T1_CYC = `CAMS_T_LOOP_T1_MS * `CAMS_CLK_KHZ,
  parameter int unsigned LOOPDN_E1_CYC =
    `CAMS_T_LOOPDN_E1_MS * `CAMS_CLK_KHZ,
  parameter int unsigned LOOP_AUTO_CYC =
    `CAMS_T_LOOP_AUTO_MS * `CAMS_CLK_KHZ
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [12:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire cams_pkg::cams_live_a_t [21:0] LIVE_A_I,
  input wire cams_pkg::cams_live_b_t [21:0] LIVE_B_I,
  input wire logic [21:0] AUTO_LOOPBACK_ENABLE_I,
  input wire logic E1_MODE_I,
  input wire cams_pkg::cams_event_t [21:0] EVENT_I,
  output logic IRQ_O
);

  localparam int NCH = `CAMS_NUM_CH;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word index 10:6 selects the channel block, 5:0 the register
  function automatic logic [5:0] chan_of(input logic [10:0] idx);
    logic [5:0] ch;
    ch = 6'h3f;
    if (idx[10:6] == `CAMS_CH0_BLOCK) begin
      ch = 6'h00;
    end else if (idx[10:6] <= `CAMS_LAST_BLOCK) begin
      ch = {1'b0, idx[10:6]} + 6'h01;
    end
    return ch;
  endfunction

  function automatic logic is_reg(input logic [5:0] r);
    return (r >= `CAMS_IDX_MASK_A && r <= `CAMS_IDX_LIVE_B) ||
           (r >= `CAMS_IDX_LATCH_B && r <= `CAMS_IDX_EDGE_SEL);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  cams_pkg::cams_live_a_t [21:0] live_a_s1_r, live_a_s2_r;
  cams_pkg::cams_live_b_t [21:0] live_b_s1_r, live_b_s2_r;
  logic [21:0] auto_en_s1_r, auto_en_s2_r;
  logic e1_s1_r, e1_s2_r;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      live_a_s1_r <= '0;
      live_a_s2_r <= '0;
      live_b_s1_r <= '0;
      live_b_s2_r <= '0;
      auto_en_s1_r <= 22'h000000;
      auto_en_s2_r <= 22'h000000;
      e1_s1_r <= 1'b0;
      e1_s2_r <= 1'b0;
    end else begin
      live_a_s1_r <= LIVE_A_I;
      live_a_s2_r <= live_a_s1_r;
      live_b_s1_r <= LIVE_B_I;
      live_b_s2_r <= live_b_s1_r;
      auto_en_s1_r <= AUTO_LOOPBACK_ENABLE_I;
      auto_en_s2_r <= auto_en_s1_r;
      e1_s1_r <= E1_MODE_I;
      e1_s2_r <= e1_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Loop code persistence timers
  // ----------------------------------------------------------------
  // A single timer per code; the limit follows the current mode, so a
  // mode change mid-count simply compares against the new limit.
  logic [27:0] up_cnt_r [NCH];
  logic [27:0] dn_cnt_r [NCH];
  logic [21:0] up_seen_r, dn_seen_r;
  logic [27:0] up_lim [NCH];
  logic [27:0] dn_lim [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (auto_en_s2_r[c]) begin
        up_lim[c] = LOOP_AUTO_CYC[27:0];
        dn_lim[c] = LOOP_AUTO_CYC[27:0];
      end else begin
        up_lim[c] = LOOP_T1_CYC[27:0];
        dn_lim[c] = e1_s2_r ? LOOPDN_E1_CYC[27:0]
                            : LOOP_T1_CYC[27:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int c = 0; c < NCH; c++) begin
        up_cnt_r[c] <= 28'h0000000;
        dn_cnt_r[c] <= 28'h0000000;
      end
      up_seen_r <= 22'h000000;
      dn_seen_r <= 22'h000000;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!live_b_s2_r[c].loopup_code_present) begin
          up_cnt_r[c] <= 28'h0000000;
          up_seen_r[c] <= 1'b0;
        end else if (up_cnt_r[c] < up_lim[c]) begin
          up_cnt_r[c] <= up_cnt_r[c] + 28'h0000001;
        end else begin
          up_seen_r[c] <= 1'b1;
        end
        if (!live_b_s2_r[c].loopdown_code_present) begin
          dn_cnt_r[c] <= 28'h0000000;
          dn_seen_r[c] <= 1'b0;
        end else if (dn_cnt_r[c] < dn_lim[c]) begin
          dn_cnt_r[c] <= dn_cnt_r[c] + 28'h0000001;
        end else begin
          dn_seen_r[c] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Live status images
  // ----------------------------------------------------------------
  logic [7:0] stat_a [NCH];
  logic [7:0] stat_b [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      stat_a[c] = {live_a_s2_r[c].auto_loopback_active, 2'b00,
                   live_a_s2_r[c].driver_overload,
                   live_a_s2_r[c].tx_clock_absent,
                   live_a_s2_r[c].tx_signal_absent,
                   live_a_s2_r[c].system_signal_absent,
                   live_a_s2_r[c].line_signal_absent};
      stat_b[c] = {live_b_s2_r[c].system_side_alarm_indication,
                   live_b_s2_r[c].line_side_alarm_indication,
                   live_b_s2_r[c].prbs_sync_flag, 3'b000,
                   up_seen_r[c], dn_seen_r[c]};
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  cams_pkg::cams_bus_st_t st_r;
  logic [10:0] rd_idx_r;
  logic [10:0] wr_idx_r;
  logic wr_pend_r;
  logic hready_r, hresp_r;
  logic [31:0] hrdata_r;
  logic addr_ok;
  logic [5:0] rd_ch, wr_ch;

  assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
  assign rd_ch = chan_of(rd_idx_r);
  assign wr_ch = chan_of(wr_idx_r);

  // Reads take one wait state so that a write in the preceding data
  // phase is already stored when the read value is sampled.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= cams_pkg::CAMS_ST_IDLE;
      rd_idx_r <= 11'h000;
      wr_idx_r <= 11'h000;
      wr_pend_r <= 1'b0;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      wr_pend_r <= 1'b0;
      case (st_r)
        // A read data phase overlaps the next address phase, so take it
        cams_pkg::CAMS_ST_IDLE, cams_pkg::CAMS_ST_RDD: begin
          if (addr_ok && HWRITE_I) begin
            wr_idx_r <= HADDR_I[12:2];
            wr_pend_r <= 1'b1;
            st_r <= cams_pkg::CAMS_ST_IDLE;
          end else if (addr_ok) begin
            rd_idx_r <= HADDR_I[12:2];
            hready_r <= 1'b0;
            st_r <= cams_pkg::CAMS_ST_RDW;
          end else begin
            st_r <= cams_pkg::CAMS_ST_IDLE;
          end
        end
        cams_pkg::CAMS_ST_RDW: begin
          hready_r <= 1'b1;
          st_r <= cams_pkg::CAMS_ST_RDD;
        end
        default: begin
          hready_r <= 1'b1;
          st_r <= cams_pkg::CAMS_ST_IDLE;
        end
      endcase
    end
  end

  logic rd_take;
  logic wr_take;
  assign rd_take = (st_r == cams_pkg::CAMS_ST_RDW) &&
                   (rd_ch != 6'h3f) && is_reg(rd_idx_r[5:0]);
  assign wr_take = wr_pend_r && (wr_ch != 6'h3f);

  // ----------------------------------------------------------------
  // Software registers and latched status
  // ----------------------------------------------------------------
  logic [7:0] mask_a_r [NCH];
  logic [7:0] mask_b_r [NCH];
  logic [7:0] edge_r [NCH];
  logic [7:0] latch_b_r [NCH];
  logic [7:0] latch_ev_r [NCH];
  logic [7:0] prev_b_r [NCH];
  logic [7:0] both_sel [NCH];
  logic [7:0] set_b [NCH];
  logic [7:0] set_ev [NCH];
  logic [7:0] clr_b [NCH];
  logic [7:0] clr_ev [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      both_sel[c] = {edge_r[c][`CAMS_B_ES_AIS], edge_r[c][`CAMS_B_ES_AIS],
                     edge_r[c][`CAMS_B_ES_PA], 3'b000,
                     edge_r[c][`CAMS_B_ES_LOOP],
                     edge_r[c][`CAMS_B_ES_LOOP]};
      set_b[c] = (stat_b[c] & ~prev_b_r[c]) |
                 (both_sel[c] & ~stat_b[c] & prev_b_r[c]);
      set_ev[c] = {2'b00, EVENT_I[c]};
      clr_b[c] = 8'h00;
      clr_ev[c] = 8'h00;
      if (wr_take && wr_ch == c[5:0]) begin
        if (wr_idx_r[5:0] == `CAMS_IDX_LATCH_B) begin
          clr_b[c] = HWDATA_I[7:0];
        end
        if (wr_idx_r[5:0] == `CAMS_IDX_LATCH_EV) begin
          clr_ev[c] = HWDATA_I[7:0];
        end
      end
      if (rd_take && rd_ch == c[5:0]) begin
        if (rd_idx_r[5:0] == `CAMS_IDX_LATCH_B) begin
          clr_b[c] = 8'hff;
        end
        if (rd_idx_r[5:0] == `CAMS_IDX_LATCH_EV) begin
          clr_ev[c] = 8'hff;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int c = 0; c < NCH; c++) begin
        mask_a_r[c] <= `CAMS_RST_MASK_A;
        mask_b_r[c] <= `CAMS_RST_MASK_B;
        edge_r[c] <= `CAMS_RST_STATUS;
      end
    end else if (wr_take) begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_ch == c[5:0]) begin
          case (wr_idx_r[5:0])
            `CAMS_IDX_MASK_A: begin
              mask_a_r[c] <= HWDATA_I[7:0];
            end
            `CAMS_IDX_MASK_B: begin
              mask_b_r[c] <= HWDATA_I[7:0];
            end
            `CAMS_IDX_EDGE_SEL: begin
              edge_r[c] <= HWDATA_I[7:0] & 8'h61;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Hardware set wins over a same-cycle clear, so no event is lost
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int c = 0; c < NCH; c++) begin
        latch_b_r[c] <= `CAMS_RST_STATUS;
        latch_ev_r[c] <= `CAMS_RST_STATUS;
        prev_b_r[c] <= `CAMS_RST_STATUS;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        prev_b_r[c] <= stat_b[c];
        latch_b_r[c] <= (latch_b_r[c] & ~clr_b[c]) | set_b[c];
        latch_ev_r[c] <= (latch_ev_r[c] & ~clr_ev[c]) | set_ev[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      if (rd_ch == c[5:0]) begin
        case (rd_idx_r[5:0])
          `CAMS_IDX_MASK_A: rd_val = mask_a_r[c];
          `CAMS_IDX_MASK_B: rd_val = mask_b_r[c];
          `CAMS_IDX_LIVE_A: rd_val = stat_a[c];
          `CAMS_IDX_LIVE_B: rd_val = stat_b[c];
          `CAMS_IDX_LATCH_B: rd_val = latch_b_r[c];
          `CAMS_IDX_LATCH_EV: rd_val = latch_ev_r[c];
          `CAMS_IDX_EDGE_SEL: rd_val = edge_r[c];
          default: rd_val = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hrdata_r <= 32'h00000000;
    end else if (st_r == cams_pkg::CAMS_ST_RDW) begin
      hrdata_r <= {24'h000000, rd_val};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  logic irq_nxt;
  logic irq_r;
  always_comb begin
    irq_nxt = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      irq_nxt = irq_nxt | (|(latch_b_r[c] & ~mask_a_r[c])) |
                (|(latch_ev_r[c] & ~mask_b_r[c]));
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign IRQ_O = irq_r;
  assign HRDATA_O = hrdata_r;
  assign HREADYOUT_O = hready_r;
  assign HRESP_O = hresp_r;

endmodule
`default_nettype wire

// ### bench/cams_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module cams_top_asserts (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire cams_pkg::cams_live_b_t [21:0] LIVE_B_I,
  input wire cams_pkg::cams_event_t [21:0] EVENT_I,
  input wire logic IRQ_O
);
  // ----------------------------------------------------------------
  // Helpers: cycles since a possible interrupt cause or bus transfer
  // ----------------------------------------------------------------
  logic taken;
  logic cause;
  cams_pkg::cams_live_b_t [21:0] lb_q_r;
  logic [3:0] cause_cnt_r;
  logic [3:0] bus_cnt_r;
  assign taken = HSEL_I & HREADY_I & HTRANS_I[1];
  // Any live level counts, since loop codes rise long after their input
  assign cause = (|EVENT_I) | (|LIVE_B_I) | (LIVE_B_I != lb_q_r) | taken;
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lb_q_r <= '0;
      cause_cnt_r <= 4'hf;
      bus_cnt_r <= 4'hf;
    end else begin
      lb_q_r <= LIVE_B_I;
      cause_cnt_r <= cause ? 4'h0 : cause_cnt_r + {3'h0, cause_cnt_r != 4'hf};
      bus_cnt_r <= taken ? 4'h0 : bus_cnt_r + {3'h0, bus_cnt_r != 4'hf};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_READ_ONE_WAIT: assert property (taken && !HWRITE_I |=>
    !HREADYOUT_O ##1 HREADYOUT_O) else $error("read wait state wrong");
  AST_WRITE_NO_WAIT: assert property (taken && HWRITE_I |=>
    HREADYOUT_O) else $error("write stalled");
  AST_RESP_OKAY: assert property (HRESP_O == 1'b0)
    else $error("response not okay");
  AST_RDATA_NARROW: assert property (HRDATA_O[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_RDATA_ON_READ: assert property ($changed(HRDATA_O) |->
    $rose(HREADYOUT_O)) else $error("read data moved outside a read");
  AST_IRQ_HAS_CAUSE: assert property ($rose(IRQ_O) |->
    cause_cnt_r < 4'h8) else $error("interrupt rose without cause");
  AST_IRQ_FALL_BY_BUS: assert property ($fell(IRQ_O) |->
    bus_cnt_r < 4'h8) else $error("interrupt fell without bus access");
  AST_IRQ_RESET_LOW: assert property ($rose(RST_N_I) |->
    !IRQ_O ##1 !IRQ_O) else $error("interrupt high after reset");

  CV_READ: cover property (taken && !HWRITE_I);
  CV_WRITE: cover property (taken && HWRITE_I);
  CV_IRQ: cover property ($rose(IRQ_O));
endmodule

bind cams_top cams_top_asserts cams_top_asserts_inst (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
  .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .LIVE_B_I(LIVE_B_I), .EVENT_I(EVENT_I), .IRQ_O(IRQ_O));

`default_nettype wire

// ### bench/channel_alarm_mask_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, e); end end

module channel_alarm_mask_status_tb;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, e1 = 1'b0;
  logic [12:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rd;
  logic hready, hresp, irq;
  logic [21:0] autolb = '0;
  cams_pkg::cams_live_a_t [21:0] la = '0;
  cams_pkg::cams_live_b_t [21:0] lb = '0;
  cams_pkg::cams_event_t [21:0] ev = '0;
  int error_cnt = 0, checks = 0, ch, lim;
  logic [7:0] m, bv, exp_ma [22];

  // Short loop limits keep the run brief; expectations use these values
  cams_top #(.LOOP_T1_CYC(40), .LOOPDN_E1_CYC(30), .LOOP_AUTO_CYC(100))
    cams_top_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .LIVE_A_I(la), .LIVE_B_I(lb),
    .AUTO_LOOPBACK_ENABLE_I(autolb), .E1_MODE_I(e1), .EVENT_I(ev),
    .IRQ_O(irq));

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  function automatic logic [12:0] adr(input int c, input int r);
    return 13'(((c == 0) ? 'h7c0 + r : (c - 1) * 'h40 + r) * 4);
  endfunction

  task automatic bus(input logic w, input int c, input int r,
                     input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= adr(c, r);
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= 32'(d);
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rchk(input int c, input int r, input logic [7:0] e);
    bus(1'b0, c, r, 8'h00);
    `CHK(rd, 32'(e))
  endtask

  task automatic pulse(input int c, input int b);
    @(posedge clk);
    ev[c] <= 6'(1 << b);
    @(posedge clk);
    ev[c] <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic sys_alarm(input logic v);
    lb[5][4] <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(45));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 22; c++) begin
      rchk(c, 'h1c, 8'hef);
      rchk(c, 'h1d, 8'h3f);
      rchk(c, 'h1e, 8'h00);
      rchk(c, 'h1f, 8'h00);
    end
    // Random values per channel expose aliasing of the map
    for (int c = 0; c < 22; c++) begin
      exp_ma[c] = 8'($urandom);
      bus(1'b1, c, 'h1c, exp_ma[c]);
      bus(1'b1, c, 'h1e, 8'hff);
    end
    for (int c = 0; c < 22; c++) begin
      rchk(c, 'h1c, exp_ma[c]);
      rchk(c, 'h1e, 8'h00);
    end
    rchk(0, 'h30, 8'h00);
    for (int k = 0; k < 8; k++) begin
      ch = $urandom_range(21, 0);
      la[ch] <= 6'($urandom);
      lb[ch] <= {3'($urandom), 2'b00};
      repeat (4) @(posedge clk);
      rchk(ch, 'h1e, {la[ch][5], 2'b00, la[ch][4:0]});
      rchk(ch, 'h1f, {lb[ch][4:2], 5'h00});
      la[ch] <= '0;
      lb[ch] <= '0;
      repeat (4) @(posedge clk);
      bus(1'b0, ch, 'h21, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      ch = $urandom_range(21, 0);
      m = 8'h3f & ~(8'h01 << i);
      bus(1'b1, ch, 'h1d, m);
      rchk(ch, 'h1d, m);
      pulse(ch, i);
      `CHK(irq, 1'b1)
      rchk(ch, 'h22, 8'h01 << i);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      pulse(ch, (i + 1) % 6);
      `CHK(irq, 1'b0)
      bus(1'b1, ch, 'h22, 8'h3f);
      bus(1'b1, ch, 'h1d, 8'h3f);
    end
    bus(1'b1, 5, 'h1c, 8'h7f);
    sys_alarm(1'b1);
    `CHK(irq, 1'b1)
    rchk(5, 'h1f, 8'h80);
    bus(1'b1, 5, 'h21, 8'h80);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    sys_alarm(1'b0);
    `CHK(irq, 1'b0)
    sys_alarm(1'b1);
    rchk(5, 'h21, 8'h80);
    bus(1'b1, 5, 'h23, 8'hff);
    rchk(5, 'h23, 8'h61);
    sys_alarm(1'b0);
    `CHK(irq, 1'b1)
    rchk(5, 'h21, 8'h80);
    bus(1'b1, 5, 'h23, 8'h00);
    bus(1'b1, 5, 'h1c, 8'hef);
    bus(1'b1, 3, 'h1c, 8'hfc);
    // Cases: loop-up plain, loop-down T1, loop-down E1, loop-up automatic
    for (int k = 0; k < 4; k++) begin
      lim = (k == 3) ? 100 : (k == 2) ? 30 : 40;
      bv = (k == 1 || k == 2) ? 8'h01 : 8'h02;
      e1 <= (k == 2);
      autolb[3] <= (k == 3);
      repeat (4) @(posedge clk);
      lb[3][1:0] <= bv[1:0];
      repeat (lim - 8) @(posedge clk);
      rchk(3, 'h1f, 8'h00);
      repeat (10) @(posedge clk);
      rchk(3, 'h1f, bv);
      `CHK(irq, 1'b1)
      lb[3] <= '0;
      repeat (4) @(posedge clk);
      rchk(3, 'h21, bv);
    end
    tally_and_finish;
  end
endmodule

`default_nettype wire
